// ==== hdl/power_up_softstart_sequencer.sv ====
// Power-up, soft-start and shutdown sequencer
`timescale 1ns/1ps
`default_nettype none
`include "softstart_params.svh"
module power_up_softstart_sequencer #(
   parameter int PH1_TAIL = `PH1_TAIL_CYC,
   parameter int PH2_HOLD = `PH2_HOLD_CYC,
   parameter int PH3_HOLD = `PH3_HOLD_CYC
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_aux_regulator_pin,
   input wire logic i_core_rail_below_low,
   input wire logic i_core_rail_above_high,
   input wire logic i_run_control_bit,
   input wire logic i_master_mode,
   input wire logic i_output_at_max,
   input wire logic i_fault_latch,
   output logic o_core_reg_enable,
   output logic o_gate_reg_enable,
   output logic o_por,
   output logic o_device_on,
   output logic [1:0] o_freq_div,
   output logic [1:0] o_current_limit,
   output logic o_channels_enable,
   output logic o_fault_latched
);
   softstart_pkg::seq_state_t state_ff, nxt_state;
   logic uvlo_ff, nxt_uvlo;
   logic run_d_ff, fault_ff, max_seen_ff, chan_ff, gate_ff;
   logic [1:0] fdiv_ff, ilim_ff;
   logic [31:0] cnt_ff;
   logic run_rise, off_req, cnt_done, por;
   logic [31:0] limit;

   assign o_core_reg_enable = i_aux_regulator_pin;
   assign nxt_uvlo = i_core_rail_below_low ? 1'b1 : (i_core_rail_above_high ? 1'b0 : uvlo_ff);
   // aux pin low is a power-on reset
   assign por = uvlo_ff | ~i_aux_regulator_pin;
   assign o_por = por;
   assign run_rise = i_run_control_bit & ~run_d_ff;
   assign off_req = ~i_run_control_bit | fault_ff | por;
   assign limit = (state_ff == softstart_pkg::ST_MS_HALF) ? PH2_HOLD :
      (state_ff == softstart_pkg::ST_MS_FORTY) ? PH3_HOLD : PH1_TAIL;
   assign cnt_done = (cnt_ff >= limit - 1);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         softstart_pkg::ST_OFF: begin
            if (run_rise && !por && !fault_ff) begin
               nxt_state = i_master_mode ? softstart_pkg::ST_MS_RAMP : softstart_pkg::ST_SA_RAMP;
            end
         end
         softstart_pkg::ST_SA_RAMP: begin
            if (max_seen_ff && cnt_done) begin
               nxt_state = softstart_pkg::ST_SA_RUN;
            end
         end
         softstart_pkg::ST_MS_RAMP: begin
            if (max_seen_ff && cnt_done) begin
               nxt_state = softstart_pkg::ST_MS_HALF;
            end
         end
         softstart_pkg::ST_MS_HALF: begin
            if (cnt_done) begin
               nxt_state = softstart_pkg::ST_MS_FORTY;
            end
         end
         softstart_pkg::ST_MS_FORTY: begin
            if (cnt_done) begin
               nxt_state = softstart_pkg::ST_MS_RUN;
            end
         end
         softstart_pkg::ST_SA_RUN, softstart_pkg::ST_MS_RUN: begin
         end
         default: begin
            nxt_state = softstart_pkg::ST_OFF;
         end
      endcase
      if (off_req) begin
         nxt_state = softstart_pkg::ST_OFF;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         uvlo_ff <= 1'b1;
      end else begin
         uvlo_ff <= nxt_uvlo;
      end
   end

   // run bit reads zero after power-on reset
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         run_d_ff <= 1'b0;
      end else begin
         run_d_ff <= i_run_control_bit & ~por;
      end
   end

   // fault left by reset, power-on reset or run bit low
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         fault_ff <= 1'b0;
      end else if (i_fault_latch && state_ff != softstart_pkg::ST_OFF) begin
         fault_ff <= 1'b1;
      end else if (por || !i_run_control_bit) begin
         fault_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= softstart_pkg::ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // wait for max in ramp states, then count tail; hold phases count at once
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         max_seen_ff <= 1'b0;
         cnt_ff <= 32'h0000_0000;
      end else if (nxt_state != state_ff) begin
         max_seen_ff <= 1'b0;
         cnt_ff <= 32'h0000_0000;
      end else begin
         max_seen_ff <= max_seen_ff | i_output_at_max;
         if (max_seen_ff || state_ff == softstart_pkg::ST_MS_HALF
               || state_ff == softstart_pkg::ST_MS_FORTY) begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
         end
      end
   end

   // Phase outputs
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         fdiv_ff <= `FDIV_NOMINAL;
         ilim_ff <= `ILIM_NOMINAL;
         chan_ff <= 1'b0;
         gate_ff <= 1'b0;
      end else begin
         gate_ff <= (nxt_state != softstart_pkg::ST_OFF);
         case (nxt_state)
            softstart_pkg::ST_SA_RAMP: begin
               fdiv_ff <= `FDIV_QUARTER;
               ilim_ff <= `ILIM_20PCT;
               chan_ff <= 1'b0;
            end
            softstart_pkg::ST_SA_RUN: begin
               fdiv_ff <= `FDIV_NOMINAL;
               ilim_ff <= `ILIM_NOMINAL;
               chan_ff <= (state_ff == softstart_pkg::ST_SA_RUN);
            end
            softstart_pkg::ST_MS_RAMP: begin
               fdiv_ff <= `FDIV_EIGHTH;
               ilim_ff <= `ILIM_20PCT;
               chan_ff <= 1'b1;
            end
            softstart_pkg::ST_MS_HALF: begin
               fdiv_ff <= `FDIV_HALF;
               ilim_ff <= `ILIM_20PCT;
               chan_ff <= 1'b1;
            end
            softstart_pkg::ST_MS_FORTY: begin
               fdiv_ff <= `FDIV_NOMINAL;
               ilim_ff <= `ILIM_40PCT;
               chan_ff <= 1'b1;
            end
            softstart_pkg::ST_MS_RUN: begin
               fdiv_ff <= `FDIV_NOMINAL;
               ilim_ff <= `ILIM_NOMINAL;
               chan_ff <= 1'b1;
            end
            default: begin
               fdiv_ff <= `FDIV_NOMINAL;
               ilim_ff <= `ILIM_NOMINAL;
               chan_ff <= 1'b0;
            end
         endcase
      end
   end

   assign o_gate_reg_enable = gate_ff;
   assign o_device_on = gate_ff;
   assign o_freq_div = fdiv_ff;
   assign o_current_limit = ilim_ff;
   assign o_channels_enable = chan_ff;
   assign o_fault_latched = fault_ff;
endmodule
`default_nettype wire

// ==== inc/softstart_params.svh ====
// Timing counts, encodings and functional notes for the soft-start sequencer
// Functional notes
// - The core regulator enable follows the aux regulator pin, active when high or floating.
// - A core rail below the lower undervoltage threshold turns the device off, unlatched.
// - A rise past the upper threshold turns it on again, and a fall then rise is a power-on reset; the code stays off until the run bit is set again.
// - A latched fault is left only by a power-on reset or by clearing then setting the run bit.
// - The gate regulator is off while disabled, and the core regulator follows only the aux pin.
// - After power-on reset the run bit in the main config register is zero and the device stays off.
// - Soft-start begins at once when the run bit becomes set.
// - Standalone phase one runs quarter frequency, 20% limit, channels off, until 1 ms after max.
// - Standalone phase two restores frequency and limit first, then enables the channels.
// - Master phase one runs eighth frequency, 20% limit, channels on, until 1 ms after max.
// - Master phase two runs half frequency for about 2 ms.
// - Master phase three runs nominal frequency and 40% limit for about 5 ms.
// - Master phase four restores the nominal current limit.
// - Clearing the run bit shuts the device down.
// - Clearing the run bit keeps the configuration registers intact.
// - Turning off through the aux pin is a power-on reset that clears all registers.
`ifndef SOFTSTART_PARAMS_SVH
`define SOFTSTART_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define PH1_TAIL_US 1000
`define PH2_HOLD_US 2000
`define PH3_HOLD_US 5000
`define PH1_TAIL_CYC ((`PH1_TAIL_US * 1000) / `CLK_PERIOD_NS)
`define PH2_HOLD_CYC ((`PH2_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define PH3_HOLD_CYC ((`PH3_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define FDIV_NOMINAL 2'h0
`define FDIV_HALF 2'h1
`define FDIV_QUARTER 2'h2
`define FDIV_EIGHTH 2'h3
`define ILIM_NOMINAL 2'h0
`define ILIM_20PCT 2'h1
`define ILIM_40PCT 2'h2
`endif

// ==== inc/softstart_pkg.sv ====
// Types for the soft-start sequencer
package softstart_pkg;
   typedef enum logic [6:0] {
      ST_OFF = 7'b000_0001,
      ST_SA_RAMP = 7'b000_0010,
      ST_SA_RUN = 7'b000_0100,
      ST_MS_RAMP = 7'b000_1000,
      ST_MS_HALF = 7'b001_0000,
      ST_MS_FORTY = 7'b010_0000,
      ST_MS_RUN = 7'b100_0000
   } seq_state_t;
endpackage

// ==== verification/softstart_monitor.sv ====
// Assertion checker for the soft-start sequencer
`timescale 1ns/1ps
`default_nettype none
`include "softstart_params.svh"
module softstart_monitor (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_aux_regulator_pin,
   input wire logic i_run_control_bit,
   input wire logic i_master_mode,
   input wire logic i_fault_latch,
   input wire logic o_core_reg_enable,
   input wire logic o_gate_reg_enable,
   input wire logic o_por,
   input wire logic o_device_on,
   input wire logic [1:0] o_freq_div,
   input wire logic [1:0] o_current_limit,
   input wire logic o_channels_enable,
   input wire logic o_fault_latched
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   a_core_follows_aux: assert property (o_core_reg_enable == i_aux_regulator_pin)
      else $error("core enable wrong");
   a_gate_tracks_on: assert property (o_gate_reg_enable == o_device_on)
      else $error("gate enable wrong");
   a_por_forces_off: assert property (o_por |=> !o_device_on)
      else $error("on during reset");
   a_run_starts_seq: assert property ($rose(i_run_control_bit) && !o_por
      && !o_fault_latched && !i_fault_latch && !o_device_on |=> o_device_on)
      else $error("start missed");
   a_run_low_off: assert property (!i_run_control_bit |=> !o_device_on && !o_fault_latched)
      else $error("shutdown missed");
   a_sa_first_phase: assert property ($rose(o_device_on) && !$past(i_master_mode)
      |-> o_freq_div == `FDIV_QUARTER && o_current_limit == `ILIM_20PCT && !o_channels_enable)
      else $error("standalone ramp wrong");
   a_ms_first_phase: assert property ($rose(o_device_on) && $past(i_master_mode)
      |-> o_freq_div == `FDIV_EIGHTH && o_current_limit == `ILIM_20PCT && o_channels_enable)
      else $error("master ramp wrong");
   a_chan_after_nom: assert property ($rose(o_channels_enable) && $past(o_device_on)
      |-> $past(o_freq_div) == `FDIV_NOMINAL && $past(o_current_limit) == `ILIM_NOMINAL)
      else $error("channels too early");
endmodule
bind power_up_softstart_sequencer softstart_monitor mon (.*);
`default_nettype wire

// ==== verification/host_model.sv ====
// Host model that sets and clears the run control bit
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_clock,
   input wire logic i_set,
   input wire logic i_clear,
   input wire logic i_por,
   output logic o_run_control_bit
);
   always_ff @(posedge i_clock) begin
      if (i_por || i_clear) begin
         o_run_control_bit <= 1'b0;
      end else if (i_set) begin
         o_run_control_bit <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== verification/test_power_up_softstart_sequencer.sv ====
// Self-checking bench for the soft-start sequencer
`timescale 1ns/1ps
`default_nettype none
`include "softstart_params.svh"
module test_power_up_softstart_sequencer;
   localparam int TL [3] = '{10, 20, 50};
   localparam logic [4:0] EX [2][4] = '{
      '{{`FDIV_QUARTER, `ILIM_20PCT, 1'b0}, {`FDIV_NOMINAL, `ILIM_NOMINAL, 1'b1}, 5'h0, 5'h0},
      '{{`FDIV_EIGHTH, `ILIM_20PCT, 1'b1}, {`FDIV_HALF, `ILIM_20PCT, 1'b1},
      {`FDIV_NOMINAL, `ILIM_40PCT, 1'b1}, {`FDIV_NOMINAL, `ILIM_NOMINAL, 1'b1}}};
   logic i_clock = 0, i_reset = 1, aux = 1, blw = 0, abv = 0, mm = 0;
   logic at_max = 0, flt = 0, set = 0, clr = 0;
   wire logic run, core, gate, por, on, chan, fl;
   wire logic [1:0] fdiv, ilim;
   int num_errors = 0, n_checks = 0, cyc = 0, n, p;
   always #5 i_clock = ~i_clock;
   host_model host (.i_clock(i_clock), .i_set(set), .i_clear(clr), .i_por(por),
      .o_run_control_bit(run));
   power_up_softstart_sequencer #(.PH1_TAIL(TL[0]), .PH2_HOLD(TL[1]), .PH3_HOLD(TL[2])) dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_aux_regulator_pin(aux),
      .i_core_rail_below_low(blw), .i_core_rail_above_high(abv),
      .i_run_control_bit(run), .i_master_mode(mm), .i_output_at_max(at_max),
      .i_fault_latch(flt), .o_core_reg_enable(core), .o_gate_reg_enable(gate),
      .o_por(por), .o_device_on(on), .o_freq_div(fdiv), .o_current_limit(ilim),
      .o_channels_enable(chan), .o_fault_latched(fl));
   task automatic chk(string nm, logic [4:0] e, logic [4:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic host_do(logic v);
      @(posedge i_clock);
      set <= v;
      clr <= !v;
      @(posedge i_clock);
      set <= 0;
      clr <= 0;
      repeat (2) @(negedge i_clock);
   endtask
   task automatic rails(logic b, logic a);
      @(posedge i_clock);
      blw <= b;
      abv <= a;
      repeat (5) @(negedge i_clock);
   endtask
   task automatic seq(logic m);
      @(posedge i_clock);
      mm <= m;
      at_max <= 0;
      host_do(1);
      chk("ramp", EX[m][0], {fdiv, ilim, chan});
      repeat ($urandom_range(40, 5)) @(negedge i_clock);
      chk("ramp hold", EX[m][0], {fdiv, ilim, chan});
      @(posedge i_clock);
      at_max <= 1;
      for (p = 1; p <= (m ? 3 : 1); p++) begin
         n = 0;
         do begin
            @(negedge i_clock);
            n++;
         end while ({fdiv, ilim, chan} === EX[m][p - 1] && n < 900);
         chk("phase len", 5'h1, n >= TL[p - 1] - 2 && n <= TL[p - 1] + 3);
         @(negedge i_clock);
         chk("phase", EX[m][p], {fdiv, ilim, chan});
      end
   endtask
   initial begin
      void'($urandom(79));
      repeat (16) @(posedge i_clock);
      i_reset <= 0;
      repeat (2) @(negedge i_clock);
      chk("por", 5'h2, {3'h0, por, on});
      rails(0, 1);
      chk("idle", 5'h0, {3'h0, por, on});
      seq(0);
      host_do(0);
      chk("shutdown", 5'h10, {core, gate, fdiv, chan});
      seq(1);
      @(posedge i_clock);
      flt <= 1;
      @(posedge i_clock);
      flt <= 0;
      repeat (2) @(negedge i_clock);
      chk("fault", 5'h1, {4'h0, fl});
      host_do(0);
      chk("fault clear", 5'h0, {3'h0, fl, on});
      seq(1);
      rails(1, 0);
      chk("uvlo", 5'h2, {3'h0, por, on});
      rails(0, 1);
      chk("uvlo rise", 5'h0, {3'h0, por, on});
      seq(1'($urandom_range(1, 0)));
      @(posedge i_clock);
      aux <= 0;
      repeat (2) @(negedge i_clock);
      chk("aux off", 5'h2, {2'h0, core, por, on});
      print_verdict();
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
endmodule
`default_nettype wire
